// [rtl/fcl_defines.svh]
// register offsets, field positions, reset values and limits of the feedback block
`ifndef FCL_DEFINES_SVH
`define FCL_DEFINES_SVH

// ==========================================================================
// register byte offsets
`define FCL_A_CTRL 8'h00
`define FCL_A_NUM1 8'h04
`define FCL_A_NUM2 8'h08
`define FCL_A_DEN1 8'h0c
`define FCL_A_DEN2 8'h10
`define FCL_A_FILT 8'h14
`define FCL_A_STAT 8'h18
`define FCL_A_LCUM 8'h1c
`define FCL_A_MCUM 8'h20
`define FCL_A_MSCL 8'h24
`define FCL_A_INFO 8'h28
`define FCL_A_BLND 8'h2c
`define FCL_A_HREF 8'h30

// ==========================================================================
// control register bit positions
`define FCL_CTRL_MODE 0
`define FCL_CTRL_INV 1
`define FCL_CTRL_HOME 2
`define FCL_CTRL_CLR 3

// ==========================================================================
// pin vector positions
`define FCL_PIN_MA 0
`define FCL_PIN_MB 1
`define FCL_PIN_LA 2
`define FCL_PIN_LB 3
`define FCL_PIN_LZ 4
`define FCL_PIN_DOG 5

// ==========================================================================
// reset values and limits
`define FCL_GEAR_RST 16'h0001
`define FCL_FILT_RST 13'h000a
`define FCL_FILT_FULL 13'h1194
`define FCL_FILT_SEMI 13'h0000

`endif

// [rtl/fcl_pkg.sv]
// types shared by the feedback block
package fcl_pkg;

    // ======================================================================
    // software settings
    typedef struct packed {
        logic fully_closed;
        logic load_invert;
        logic [15:0] num1;
        logic [15:0] num2;
        logic [15:0] den1;
        logic [15:0] den2;
        logic [12:0] filt;
    } cfg_t;

    // ======================================================================
    // home search state, one-hot
    typedef enum logic [2:0] {
        HOME_IDLE   = 3'b001,
        HOME_SEARCH = 3'b010,
        HOME_FOUND  = 3'b100
    } home_state_t;

    // ======================================================================
    // synchronised encoder and dog pins
    typedef struct packed {
        logic dog;
        logic lz;
        logic lb;
        logic la;
        logic mb;
        logic ma;
    } pins_t;

endpackage : fcl_pkg

// [rtl/fully_closed_loop_feedback.sv]
// fully closed loop feedback: counters, feedback gear, dual feedback filter, home reference
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "fcl_defines.svh"

module fully_closed_loop_feedback (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // encoder and dog pins, asynchronous
    input wire fcl_pkg::pins_t pins_i,
    // controller switching command, asynchronous
    input wire logic closed_switch_i,
    // feedback and home results
    output logic [31:0] feedback_pos_o,
    output logic closed_mode_o,
    output logic home_done_o,
    output logic home_error_o
);
    import fcl_pkg::*;

    // ======================================================================
    // declarations
    cfg_t cfg_q;
    pins_t sync1_q, sync2_q, prev_q;
    logic sw1_q, sw2_q;
    logic [1:0] step, up;
    logic [31:0] lcum_q, mcum_q, mscl_q, info_q, href_q;
    logic signed [34:0] rem_q;
    logic [31:0] num_prod, den_prod;
    logic signed [34:0] den_s;
    logic [12:0] filt_eff;
    logic signed [32:0] diff;
    logic signed [46:0] prod, quot;
    logic [31:0] blend;
    logic z_rise, dog_fall, home_go, cnt_clr;
    home_state_t home_q;

    // ======================================================================
    // input synchronisers, two flops before any use
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
            sw1_q <= 1'b0;
            sw2_q <= 1'b0;
        end else if (ce_i) begin
            sync1_q <= pins_i;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            sw1_q <= closed_switch_i;
            sw2_q <= sw1_q;
        end
    end

    // ======================================================================
    // quadrature decode, channel 0 motor, channel 1 load
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_quad
            logic a_n, b_n, a_p, b_p;
            assign a_n = g ? sync2_q.la : sync2_q.ma;
            assign b_n = g ? sync2_q.lb : sync2_q.mb;
            assign a_p = g ? prev_q.la : prev_q.ma;
            assign b_p = g ? prev_q.lb : prev_q.mb;
            // one line changed means one step; direction from gray order
            assign step[g] = (a_n ^ a_p) ^ (b_n ^ b_p);
            assign up[g] = a_p ^ b_n;
        end
    endgenerate

    // pin events and control register commands
    assign z_rise = sync2_q.lz & ~prev_q.lz;
    assign dog_fall = ~sync2_q.dog & prev_q.dog;
    assign home_go = wr_i && addr_i == `FCL_A_CTRL && wdata_i[`FCL_CTRL_HOME];
    assign cnt_clr = wr_i && addr_i == `FCL_A_CTRL && wdata_i[`FCL_CTRL_CLR];

    // ======================================================================
    // settings written by software
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q.fully_closed <= 1'b0;
            cfg_q.load_invert <= 1'b0;
            cfg_q.num1 <= `FCL_GEAR_RST;
            cfg_q.num2 <= `FCL_GEAR_RST;
            cfg_q.den1 <= `FCL_GEAR_RST;
            cfg_q.den2 <= `FCL_GEAR_RST;
            cfg_q.filt <= `FCL_FILT_RST;
        end else if (ce_i && wr_i) begin
            case (addr_i)
                `FCL_A_CTRL: begin
                    cfg_q.fully_closed <= wdata_i[`FCL_CTRL_MODE];
                    cfg_q.load_invert <= wdata_i[`FCL_CTRL_INV];
                end
                `FCL_A_NUM1: cfg_q.num1 <= wdata_i[15:0];
                `FCL_A_NUM2: cfg_q.num2 <= wdata_i[15:0];
                `FCL_A_DEN1: cfg_q.den1 <= wdata_i[15:0];
                `FCL_A_DEN2: cfg_q.den2 <= wdata_i[15:0];
                // values whose low 16 bits are above the fully closed end are held there
                `FCL_A_FILT: cfg_q.filt <= (wdata_i[15:0] > 16'(`FCL_FILT_FULL)) ?
                    `FCL_FILT_FULL : wdata_i[12:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // load-side cumulative count and information one
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lcum_q <= '0;
            info_q <= '0;
        end else if (ce_i) begin
            if (cnt_clr) begin
                lcum_q <= '0;
            end else if (step[1]) begin
                lcum_q <= (up[1] ^ cfg_q.load_invert) ? lcum_q + 32'h1 : lcum_q - 32'h1;
            end
            if (z_rise) begin
                info_q <= '0;
            end else if (step[1]) begin
                info_q <= (up[1] ^ cfg_q.load_invert) ? info_q + 32'h1 : info_q - 32'h1;
            end
        end
    end

    // ======================================================================
    // motor count and gear scaling with carried remainder
    assign num_prod = 32'(cfg_q.num1) * 32'(cfg_q.num2);
    assign den_prod = 32'(cfg_q.den1) * 32'(cfg_q.den2);
    assign den_s = $signed({3'h0, den_prod});

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mcum_q <= '0;
            mscl_q <= '0;
            rem_q <= '0;
        end else if (ce_i) begin
            if (cnt_clr) begin
                mcum_q <= '0;
                mscl_q <= '0;
                rem_q <= '0;
            end else if (step[0]) begin
                // each up motor pulse adds the numerator product to the residue, a down pulse subtracts it
                mcum_q <= up[0] ? mcum_q + 32'h1 : mcum_q - 32'h1;
                rem_q <= up[0] ? rem_q + $signed({3'h0, num_prod}) :
                    rem_q - $signed({3'h0, num_prod});
            end else if (den_prod != 32'h0 && rem_q >= den_s) begin
                // one scaled pulse per cycle; the remainder stays behind
                mscl_q <= mscl_q + 32'h1;
                rem_q <= rem_q - den_s;
            end else if (den_prod != 32'h0 && rem_q <= -den_s) begin
                mscl_q <= mscl_q - 32'h1;
                rem_q <= rem_q + den_s;
            end
        end
    end

    // ======================================================================
    // control mode and dual feedback blend
    always_comb begin
        // semi loop unless fully closed system and the switch command is on
        filt_eff = (cfg_q.fully_closed && sw2_q) ? cfg_q.filt : `FCL_FILT_SEMI;
        diff = $signed({lcum_q[31], lcum_q}) - $signed({mscl_q[31], mscl_q});
        prod = 47'(diff) * 47'($signed({1'b0, filt_eff}));
        // zero gives motor feedback, full scale gives load feedback
        quot = prod / $signed(47'(`FCL_FILT_FULL));
        blend = mscl_q + quot[31:0];
    end

    // ======================================================================
    // home search driven by the load-side mark and the dog switch
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            home_q <= HOME_IDLE;
            href_q <= '0;
            home_done_o <= 1'b0;
            home_error_o <= 1'b0;
        end else if (ce_i) begin
            case (home_q)
                HOME_IDLE: begin
                    if (home_go) begin
                        home_q <= HOME_SEARCH;
                        home_done_o <= 1'b0;
                        home_error_o <= 1'b0;
                    end
                end
                HOME_SEARCH: begin
                    if (z_rise) begin
                        href_q <= lcum_q;
                        home_q <= HOME_FOUND;
                    end else if (dog_fall) begin
                        home_error_o <= 1'b1;
                        home_q <= HOME_IDLE;
                    end
                end
                HOME_FOUND: begin
                    if (dog_fall) begin
                        home_done_o <= 1'b1;
                        home_q <= HOME_IDLE;
                    end
                end
                default: home_q <= HOME_IDLE;
            endcase
        end
    end

    // ======================================================================
    // registered outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            feedback_pos_o <= '0;
            closed_mode_o <= 1'b0;
        end else if (ce_i) begin
            feedback_pos_o <= blend;
            closed_mode_o <= cfg_q.fully_closed && sw2_q;
        end
    end

    // ======================================================================
    // read data, valid only in the cycle after the read strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= '0;
            if (rd_i) begin
                case (addr_i)
                    `FCL_A_CTRL: rdata_o <= {30'h0, cfg_q.load_invert, cfg_q.fully_closed};
                    `FCL_A_NUM1: rdata_o <= {16'h0, cfg_q.num1};
                    `FCL_A_NUM2: rdata_o <= {16'h0, cfg_q.num2};
                    `FCL_A_DEN1: rdata_o <= {16'h0, cfg_q.den1};
                    `FCL_A_DEN2: rdata_o <= {16'h0, cfg_q.den2};
                    `FCL_A_FILT: rdata_o <= {19'h0, cfg_q.filt};
                    `FCL_A_STAT: rdata_o <= {25'h0, sync2_q.dog, home_q,
                        home_error_o, home_done_o, closed_mode_o};
                    `FCL_A_LCUM: rdata_o <= lcum_q;
                    `FCL_A_MCUM: rdata_o <= mcum_q;
                    `FCL_A_MSCL: rdata_o <= mscl_q;
                    `FCL_A_INFO: rdata_o <= info_q;
                    `FCL_A_BLND: rdata_o <= feedback_pos_o;
                    `FCL_A_HREF: rdata_o <= href_q;
                    default: rdata_o <= '0;
                endcase
            end
        end
    end

endmodule : fully_closed_loop_feedback

// [sim/fcl_chk.sv]
// port checker for the fully closed loop feedback block
`timescale 1ns/1ps
module fcl_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // watched ports
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire fcl_pkg::pins_t pins_i,
    input wire logic closed_switch_i,
    input wire logic [31:0] feedback_pos_o,
    input wire logic closed_mode_o,
    input wire logic home_done_o,
    input wire logic home_error_o
);
    import fcl_pkg::*;
    // ======================================================================
    // helper logic
    logic home_go;
    logic z_seen_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // home start write on the register port
    assign home_go = ce_i && wr_i && addr_i == 8'h00 && wdata_i[2];
    // mark seen since the last home start
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            z_seen_q <= 1'b0;
        end else if (home_go) begin
            z_seen_q <= 1'b0;
        end else if (pins_i.lz) begin
            z_seen_q <= 1'b1;
        end
    end
    sequence seq_home_go;
        home_go;
    endsequence
    sequence seq_switch_off;
        (ce_i && !closed_switch_i) [*4];
    endsequence
    // ======================================================================
    // assertions
    chk_rdata_idle: assert property (ce_i && !rd_i |=> rdata_o == 32'h0)
        else $error("read data not cleared");
    chk_filt_clamp: assert property (ce_i && rd_i && addr_i == 8'h14 |=> rdata_o <= 32'h1194)
        else $error("filter above full closed value");
    chk_mode_off: assert property (seq_switch_off |=> !closed_mode_o)
        else $error("closed mode with switch off");
    chk_home_excl: assert property (!(home_done_o && home_error_o))
        else $error("home done and error together");
    chk_done_mark: assert property ($rose(home_done_o) |-> z_seen_q)
        else $error("home done without load mark");
    chk_done_hold: assert property (home_done_o && !home_go |=> home_done_o)
        else $error("home done dropped early");
    chk_home_clear: assert property (seq_home_go ##1 ce_i |-> !home_done_o && !home_error_o)
        else $error("home flags not cleared at start");
    chk_flag_dog: assert property ($rose(home_done_o) || $rose(home_error_o) |-> !pins_i.dog)
        else $error("home result while dog on");
    chk_reset_out: assert property ($rose(rst_n_i) |-> feedback_pos_o == 32'h0 && !home_done_o)
        else $error("outputs not cleared by reset");
endmodule : fcl_chk

bind fully_closed_loop_feedback fcl_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pins_i(pins_i), .closed_switch_i(closed_switch_i), .feedback_pos_o(feedback_pos_o),
    .closed_mode_o(closed_mode_o), .home_done_o(home_done_o), .home_error_o(home_error_o));

// [sim/encoder_model.sv]
// model of motor and load encoders, load mark and dog switch
`timescale 1ns/1ps
module encoder_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // commands from the bench
    input wire logic motor_step_i,
    input wire logic load_step_i,
    input wire logic mark_i,
    input wire logic dog_on_i,
    // lines towards the block
    output fcl_pkg::pins_t pins_o
);
    import fcl_pkg::*;
    logic [1:0] motor_ph_q;
    logic [1:0] load_ph_q;
    // one quadrature state change per step command
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            motor_ph_q <= 2'h0;
            load_ph_q <= 2'h0;
        end else begin
            motor_ph_q <= motor_ph_q + {1'b0, motor_step_i};
            load_ph_q <= load_ph_q + {1'b0, load_step_i};
        end
    end
    // gray phase onto lines, up order 00 01 11 10
    assign pins_o.ma = motor_ph_q[1];
    assign pins_o.mb = motor_ph_q[1] ^ motor_ph_q[0];
    assign pins_o.la = load_ph_q[1];
    assign pins_o.lb = load_ph_q[1] ^ load_ph_q[0];
    assign pins_o.lz = mark_i;
    assign pins_o.dog = dog_on_i;
endmodule : encoder_model

// [sim/fully_closed_loop_feedback_bench.sv]
// self-checking bench for the fully closed loop feedback block
`timescale 1ns/1ps
module fully_closed_loop_feedback_bench;
    import fcl_pkg::*;
    // ======================================================================
    // signals and instances
    logic clk_i, rst_n_i, ce_i, wr_i, rd_i, closed_switch_i, closed_mode_o;
    logic home_done_o, home_error_o, motor_step, load_step, mark, dog_on;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, feedback_pos_o;
    pins_t pins_i;
    int fails = 0;
    int num_checks = 0;
    fully_closed_loop_feedback DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pins_i(pins_i), .closed_switch_i(closed_switch_i), .feedback_pos_o(feedback_pos_o),
        .closed_mode_o(closed_mode_o), .home_done_o(home_done_o), .home_error_o(home_error_o));
    encoder_model u_enc (.clk_i(clk_i), .rst_n_i(rst_n_i), .motor_step_i(motor_step),
        .load_step_i(load_step), .mark_i(mark), .dog_on_i(dog_on), .pins_o(pins_i));
    // clock and watchdog
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        fails++;
        stop_test();
    end
    // ======================================================================
    // tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(what, rdata_o, exp);
    endtask : reg_rd
    // encoder steps spaced so the synchronisers see each state
    task automatic step(input bit motor, input int n);
        repeat (n) begin
            @(posedge clk_i);
            motor_step <= motor;
            load_step <= !motor;
            @(posedge clk_i);
            motor_step <= 1'b0;
            load_step <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
    endtask : step
    task automatic pass_mark;
        @(posedge clk_i);
        mark <= 1'b1;
        repeat (3) @(posedge clk_i);
        mark <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : pass_mark
    // dog-type home return, mark crossed before dog off when asked
    task automatic home(input bit with_mark);
        reg_wr(8'h00, 32'h5);
        @(posedge clk_i);
        dog_on <= 1'b1;
        repeat (4) @(posedge clk_i);
        if (with_mark) begin
            pass_mark();
        end
        dog_on <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : home
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    // ======================================================================
    // test sequence
    initial begin
        {rst_n_i, wr_i, rd_i, closed_switch_i, motor_step, load_step, mark, dog_on} = 8'h0;
        ce_i = 1'b1;
        addr_i = 8'h0;
        wdata_i = 32'h0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        reg_rd(8'h14, 32'ha, "filter");
        reg_rd(8'h04, 32'h1, "num1");
        reg_rd(8'h18, 32'h8, "status");
        reg_rd(8'h40, 32'h0, "unmapped");
        reg_wr(8'h14, 32'h1388);
        reg_rd(8'h14, 32'h1194, "filter clamp");
        step(0, 4);
        reg_rd(8'h1c, 32'h4, "load count");
        reg_rd(8'h28, 32'h4, "info1");
        pass_mark();
        reg_rd(8'h28, 32'h0, "info1 at mark");
        reg_wr(8'h00, 32'h2);
        step(0, 2);
        reg_rd(8'h1c, 32'h2, "inverted count");
        reg_wr(8'h00, 32'h8);
        reg_wr(8'h04, 32'h3);
        reg_wr(8'h10, 32'h2);
        step(1, 4);
        reg_rd(8'h20, 32'h4, "motor raw");
        reg_rd(8'h24, 32'h6, "motor scaled");
        step(1, 2);
        reg_rd(8'h24, 32'h9, "scaled remainder");
        step(0, 3);
        reg_wr(8'h00, 32'h1);
        repeat (5) @(posedge clk_i);
        check("semi feedback", feedback_pos_o, 32'h9);
        check("semi mode", {31'h0, closed_mode_o}, 32'h0);
        closed_switch_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        check("closed mode", {31'h0, closed_mode_o}, 32'h1);
        check("full feedback", feedback_pos_o, 32'h3);
        // filter kept well below half of an assumed second loop gain
        reg_wr(8'h14, 32'h5dc);
        repeat (3) @(posedge clk_i);
        check("blend feedback", feedback_pos_o, 32'h7);
        reg_rd(8'h2c, 32'h7, "blend register");
        reg_wr(8'h14, 32'h0);
        repeat (3) @(posedge clk_i);
        check("zero filter", feedback_pos_o, 32'h9);
        // writes are ignored while the clock enable is low
        ce_i <= 1'b0;
        reg_wr(8'h14, 32'h1194);
        ce_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        check("frozen write", feedback_pos_o, 32'h9);
        reg_rd(8'h14, 32'h0, "frozen filter");
        closed_switch_i <= 1'b0;
        home(1);
        check("home done", {31'h0, home_done_o}, 32'h1);
        check("home error", {31'h0, home_error_o}, 32'h0);
        reg_rd(8'h30, 32'h3, "home reference");
        home(0);
        check("no mark done", {31'h0, home_done_o}, 32'h0);
        check("no mark error", {31'h0, home_error_o}, 32'h1);
        stop_test();
    end
endmodule : fully_closed_loop_feedback_bench
